// File: core/lmsc_pkg.sv
// Purpose: shared constants and types of the scroll/current control bank
// Assumes: core_clk at 10 MHz, registers byte wide
// Notes: rule summary below travels with the constants
// What this block does
// (RULE1) up bit alone scrolls bottom toward top
// (RULE2) down bit alone scrolls top toward bottom
// (RULE3) right bit alone scrolls left toward right
// (RULE4) left bit alone scrolls leftward; resets to one
// (RULE5) step time code n gives (n+1) x 0.1 s
// (RULE6) zero or several direction bits disable scrolling
// (RULE7) conflict before start keeps normal display
// (RULE8) conflict while scrolling stops scrolling at once
// (RULE9) direction change applies from next frame
// (RULE10) one column or row shifted per step
// (RULE11) registers answer only when map select is zero
// (RULE12) soft reset bit self clears after two clocks
// (RULE13) without running clock soft reset stays set
// (RULE14) per column bit: matrix or constant current
// (RULE15) constant current level from first row LED
// (RULE16) full scale code: 15, 20, 25, 30 mA
// (RULE17) current step is full scale over fifteen
// (RULE18) constant current columns use same full scale
// (RULE19) scroll starts only with matrix and scroll enable
// (RULE20) soft reset restores defaults, idles display
package lmsc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SCROLL_CONFIG = 8'h0b;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h0d;
  localparam logic [7:0] ADDR_COL_HIGH = 8'h10;
  localparam logic [7:0] ADDR_COL_MID = 8'h11;
  localparam logic [7:0] ADDR_COL_LOW = 8'h12;
  localparam logic [7:0] ADDR_CURRENT = 8'h13;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int UP_BIT = 6;
  localparam int DOWN_BIT = 5;
  localparam int RIGHT_BIT = 4;
  localparam int LEFT_BIT = 3;
  localparam int TIME_MSB = 2;
  localparam int SOFT_RESET_BIT_BIT = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] SCROLL_CONFIG_RST = 7'h08;
  localparam logic [16:0] COL_MODE_RST = 17'h00000;
  localparam logic [1:0] CURRENT_RST = 2'h1;
  // ----------------------------------------------------------------
  // timing and geometry
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCROLL_UNIT_NS = 100_000_000;
  localparam int SCROLL_UNIT_CYCLES = SCROLL_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [1:0] SOFT_RESET_BIT_CLOCKS = 2'h2;
  localparam int NUM_COLS = 17;
  localparam int NUM_ROWS = 7;
  // ----------------------------------------------------------------
  // currents in microamps
  // ----------------------------------------------------------------
  localparam logic [14:0] FS_CODE0_UA = 15'd15000;
  localparam logic [14:0] FS_CODE1_UA = 15'd20000;
  localparam logic [14:0] FS_CODE2_UA = 15'd25000;
  localparam logic [14:0] FS_CODE3_UA = 15'd30000;
  localparam logic [14:0] STEP_DIVISOR = 15'd15;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DIR_LEFT = 2'b00,
    DIR_RIGHT = 2'b01,
    DIR_UP = 2'b10,
    DIR_DOWN = 2'b11
  } lmsc_dir_type;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } lmsc_state_type;
endpackage : lmsc_pkg

// File: core/lmsc_step_timer.sv
// Purpose: interval timer giving one pulse per scroll step
// Assumes: limit is stable while run is high
// Notes: restarts from zero whenever run drops
`timescale 1ns/10ps
module lmsc_step_timer #(
  parameter int CNT_W = 24
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [CNT_W-1:0] limit,
  output logic tick
);
  import lmsc_pkg::*;

  logic [CNT_W-1:0] cnt; // cycles into the current step
  logic [CNT_W-1:0] next_cnt;
  logic next_tick;

  // ----------------------------------------------------------------
  // count toward the limit
  // ----------------------------------------------------------------
  always_comb begin
    next_cnt = '0;
    next_tick = 1'b0;
    if (run) begin
      // pulse on the last cycle of the interval
      if (cnt >= limit - CNT_W'(1)) begin
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  // registers only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : lmsc_step_timer

// File: core/lmsc_ctrl.sv
// Purpose: scroll, soft reset, column drive and current range bank
// Assumes: register port and enables come from logic on core_clk
// Notes: external reference clock arrives as a pin and is synchronised
`timescale 1ns/10ps
module lmsc_ctrl #(
  parameter int unsigned SCROLL_UNIT = lmsc_pkg::SCROLL_UNIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic register_map_select,
  input wire logic matrix_enable,
  input wire logic scroll_enable,
  input wire logic [1:0] display_ram_select,
  input wire logic external_clock_select,
  input wire logic int_osc_tick,
  input wire logic ext_clk_pin,
  input wire logic [4*lmsc_pkg::NUM_COLS-1:0] first_row_brightness,
  output logic soft_reset_active,
  output logic scroll_active,
  output lmsc_pkg::lmsc_dir_type scroll_dir,
  output logic [4:0] scroll_offset,
  output logic scroll_shift,
  output logic frame_done,
  output logic [1:0] shown_ram_select,
  output logic [lmsc_pkg::NUM_COLS-1:0] column_const_mode,
  output logic [14:0] full_scale_ua,
  output logic [10:0] step_current_ua,
  output logic [15*lmsc_pkg::NUM_COLS-1:0] column_current_ua
);
  import lmsc_pkg::*;
  // every check below samples on the core clock and sleeps in reset
  default clocking chk_cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // full scale current from the range code
  function automatic logic [14:0] fs_of(input logic [1:0] code);
    case (code)
      2'h0: fs_of = FS_CODE0_UA;
      2'h1: fs_of = FS_CODE1_UA;
      2'h2: fs_of = FS_CODE2_UA;
      default: fs_of = FS_CODE3_UA;
    endcase
  endfunction : fs_of

  // direction from the four one-hot bits
  function automatic lmsc_dir_type dir_of(input logic [6:0] cfg);
    if (cfg[UP_BIT]) dir_of = DIR_UP;
    else if (cfg[DOWN_BIT]) dir_of = DIR_DOWN;
    else if (cfg[RIGHT_BIT]) dir_of = DIR_RIGHT;
    else dir_of = DIR_LEFT;
  endfunction : dir_of

  // ----------------------------------------------------------------
  // external clock synchroniser
  // ----------------------------------------------------------------
  logic ext_s1; // first stage, read by ext_s2 only
  logic ext_s2;
  logic ext_s3; // history for the edge detector
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= ext_clk_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  logic act_tick; // one edge of whichever clock runs the display
  assign act_tick = external_clock_select ? (ext_s2 & ~ext_s3)
                                          : int_osc_tick;

  // ----------------------------------------------------------------
  // access qualification
  // ----------------------------------------------------------------
  logic wr_ok; // map select must be zero [RULE11]
  logic rd_ok;
  assign wr_ok = reg_wr_en & ~register_map_select; // [RULE11]
  assign rd_ok = reg_rd_en & ~register_map_select; // [RULE11]

  // ----------------------------------------------------------------
  // soft reset bit
  // ----------------------------------------------------------------
  logic [1:0] soft_reset_bit_cnt; // active clock edges seen while set
  logic [1:0] next_soft_reset_bit_cnt;
  logic next_soft_reset_bit;
  logic soft_reset_bit_set;
  assign soft_reset_bit_set = wr_ok & (reg_addr == ADDR_SOFT_RESET)
                    & reg_wdata[SOFT_RESET_BIT_BIT];

  always_comb begin
    next_soft_reset_bit = soft_reset_active;
    next_soft_reset_bit_cnt = soft_reset_bit_cnt;
    if (soft_reset_bit_set) begin
      // a new write wins over the self clear
      next_soft_reset_bit = 1'b1;
      next_soft_reset_bit_cnt = 2'h0;
    end else if (soft_reset_active && act_tick) begin
      if (soft_reset_bit_cnt == SOFT_RESET_BIT_CLOCKS - 2'h1) begin
        next_soft_reset_bit = 1'b0; // [RULE12]
        next_soft_reset_bit_cnt = 2'h0;
      end else begin
        next_soft_reset_bit_cnt = soft_reset_bit_cnt + 2'h1; // [RULE12]
      end
    end
    // no clock edge: bit simply holds [RULE13]
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_active <= 1'b0;
      soft_reset_bit_cnt <= 2'h0;
    end else begin
      soft_reset_active <= next_soft_reset_bit;
      soft_reset_bit_cnt <= next_soft_reset_bit_cnt;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [6:0] scroll_cfg; // direction bits and step time
  logic [1:0] cur_sel; // full scale code
  logic [6:0] next_scroll_cfg;
  logic [NUM_COLS-1:0] next_col_mode;
  logic [1:0] next_cur_sel;

  always_comb begin
    next_scroll_cfg = scroll_cfg;
    next_col_mode = column_const_mode;
    next_cur_sel = cur_sel;
    if (soft_reset_active) begin
      // soft reset returns everything to defaults [RULE20]
      next_scroll_cfg = SCROLL_CONFIG_RST; // [RULE4] [RULE5]
      next_col_mode = COL_MODE_RST; // [RULE14]
      next_cur_sel = CURRENT_RST; // [RULE16]
    end else if (wr_ok) begin
      case (reg_addr)
        ADDR_SCROLL_CONFIG: next_scroll_cfg = reg_wdata[6:0];
        ADDR_COL_HIGH: next_col_mode[16:9] = reg_wdata; // [RULE14]
        ADDR_COL_MID: next_col_mode[8:1] = reg_wdata; // [RULE14]
        ADDR_COL_LOW: next_col_mode[0] = reg_wdata[0]; // [RULE14]
        ADDR_CURRENT: next_cur_sel = reg_wdata[1:0];
        default: ; // other offsets belong elsewhere
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scroll_cfg <= SCROLL_CONFIG_RST; // [RULE4]
      column_const_mode <= COL_MODE_RST;
      cur_sel <= CURRENT_RST;
    end else begin
      scroll_cfg <= next_scroll_cfg;
      column_const_mode <= next_col_mode;
      cur_sel <= next_cur_sel;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = reg_rdata; // holds until the next read
    if (rd_ok) begin
      case (reg_addr)
        ADDR_SCROLL_CONFIG: next_rdata = {1'b0, scroll_cfg};
        ADDR_SOFT_RESET: next_rdata = {7'h00, soft_reset_active};
        ADDR_COL_HIGH: next_rdata = column_const_mode[16:9];
        ADDR_COL_MID: next_rdata = column_const_mode[8:1];
        ADDR_COL_LOW: next_rdata = {7'h00, column_const_mode[0]};
        ADDR_CURRENT: next_rdata = {6'h00, cur_sel};
        default: next_rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // scroll sequencer
  // ----------------------------------------------------------------
  logic dir_ok; // exactly one direction bit set [RULE6]
  logic go; // all conditions to run
  logic step_tick; // from the interval timer
  logic [23:0] step_limit;
  lmsc_state_type state;
  lmsc_state_type next_state;
  lmsc_dir_type next_dir;
  logic [4:0] next_offset;
  logic [4:0] last_pos;
  logic next_shift;
  logic next_frame_done;
  logic [1:0] scroll_ram; // ram frozen at scroll start
  logic [1:0] next_scroll_ram;
  logic [1:0] next_shown;

  assign dir_ok = $onehot({scroll_cfg[UP_BIT], scroll_cfg[DOWN_BIT],
                           scroll_cfg[RIGHT_BIT], scroll_cfg[LEFT_BIT]});
  // enables, a clean direction and no soft reset [RULE19] [RULE6]
  assign go = matrix_enable & scroll_enable & dir_ok & ~soft_reset_active;
  // code n lasts n+1 units [RULE5]
  assign step_limit = 24'(({29'h0, scroll_cfg[TIME_MSB:0]} + 32'd1)
                          * SCROLL_UNIT);
  // columns for sideways, rows for vertical [RULE10]
  assign last_pos = (scroll_dir == DIR_LEFT || scroll_dir == DIR_RIGHT)
                    ? 5'(NUM_COLS - 1) : 5'(NUM_ROWS - 1);

  lmsc_step_timer #(
    .CNT_W(24)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(scroll_active),
    .limit(step_limit),
    .tick(step_tick)
  );

  always_comb begin
    next_state = state;
    next_dir = scroll_dir;
    next_offset = scroll_offset;
    next_shift = 1'b0;
    next_frame_done = 1'b0;
    next_scroll_ram = scroll_ram;
    case (state)
      ST_IDLE: begin
        // a conflict here never starts anything [RULE7]
        if (go) begin
          next_state = ST_RUN;
          next_dir = dir_of(scroll_cfg); // [RULE1] [RULE2] [RULE3] [RULE4]
          next_offset = 5'h00;
          next_scroll_ram = display_ram_select;
        end
      end
      ST_RUN: begin
        if (!go) begin
          // stop at once, back to normal display [RULE8] [RULE6]
          next_state = ST_IDLE;
          next_offset = 5'h00;
        end else if (step_tick) begin
          next_shift = 1'b1; // one line per step [RULE10]
          if (scroll_offset == last_pos) begin
            next_offset = 5'h00;
            next_frame_done = 1'b1;
            // new direction only from the next frame [RULE9]
            next_dir = dir_of(scroll_cfg);
          end else begin
            next_offset = scroll_offset + 5'h01; // [RULE10]
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // display shows idle ram during soft reset [RULE20]
    if (soft_reset_active) next_shown = 2'h0;
    else if (next_state == ST_RUN) next_shown = next_scroll_ram;
    else next_shown = display_ram_select; // [RULE6]
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      scroll_active <= 1'b0;
      scroll_dir <= DIR_LEFT;
      scroll_offset <= 5'h00;
      scroll_shift <= 1'b0;
      frame_done <= 1'b0;
      scroll_ram <= 2'h0;
      shown_ram_select <= 2'h0;
    end else begin
      state <= next_state;
      scroll_active <= (next_state == ST_RUN);
      scroll_dir <= next_dir;
      scroll_offset <= next_offset;
      scroll_shift <= next_shift;
      frame_done <= next_frame_done;
      scroll_ram <= next_scroll_ram;
      shown_ram_select <= next_shown;
    end
  end

  // ----------------------------------------------------------------
  // current scaling
  // ----------------------------------------------------------------
  logic [14:0] next_fs;
  logic [10:0] next_step;
  always_comb begin
    next_fs = fs_of(cur_sel); // [RULE16]
    next_step = 11'(fs_of(cur_sel) / STEP_DIVISOR); // [RULE17]
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      full_scale_ua <= FS_CODE1_UA;
      step_current_ua <= 11'h000;
    end else begin
      full_scale_ua <= next_fs;
      step_current_ua <= next_step;
    end
  end

  // per column drive, first row brightness times the step
  logic [15*NUM_COLS-1:0] next_col_cur; // one slice per column
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COLS; gi++) begin : g_col
      logic [14:0] next_cur;
      always_comb begin
        next_cur = 15'h0000;
        if (column_const_mode[gi]) begin
          // same full scale as the matrix [RULE15] [RULE18]
          // widened first so 2000 x 15 cannot wrap
          next_cur = {4'h0, step_current_ua}
                     * {11'h000, first_row_brightness[4*gi +: 4]};
        end
      end
      assign next_col_cur[15*gi +: 15] = next_cur;
    end
  endgenerate

  // one register process for all columns, so one writer per variable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) column_current_ua <= '0;
    else column_current_ua <= next_col_cur;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_soft_reset_bit_clears: assert property ( // [RULE12]
    soft_reset_active && act_tick && soft_reset_bit_cnt == 2'h1 && !soft_reset_bit_set
    |=> !soft_reset_active)
    else $error("soft reset did not clear after two clocks");
  a_soft_reset_bit_holds: assert property ( // [RULE13]
    soft_reset_active && !act_tick |=> soft_reset_active)
    else $error("soft reset cleared with no clock edge");
  a_conflict_stop: assert property ( // [RULE8]
    scroll_active && !dir_ok |=> !scroll_active)
    else $error("scroll kept running with bad direction");
  a_no_start: assert property ( // [RULE7]
    !scroll_active && !dir_ok |=> !scroll_active)
    else $error("scroll started with bad direction");
  a_start_enables: assert property ( // [RULE19]
    !scroll_active ##1 scroll_active
    |-> $past(matrix_enable && scroll_enable))
    else $error("scroll started without both enables");
  a_dir_at_frame: assert property ( // [RULE9]
    $past(scroll_active) && scroll_active && $changed(scroll_dir)
    |-> frame_done)
    else $error("direction changed inside a frame");
  a_step_advance: assert property ( // [RULE10]
    scroll_active && step_tick && go && scroll_offset < last_pos
    |=> scroll_shift && scroll_offset == $past(scroll_offset) + 5'h01)
    else $error("step did not advance one line");
  a_map_locked: assert property ( // [RULE11]
    reg_wr_en && register_map_select && !soft_reset_active
    |=> $stable(scroll_cfg) && $stable(cur_sel)
    && $stable(column_const_mode))
    else $error("write taken while map select set");
  // one cycle only: a host write may follow the clear at once
  a_soft_reset_bit_default: assert property ( // [RULE20]
    soft_reset_active |=> scroll_cfg == SCROLL_CONFIG_RST
    && cur_sel == CURRENT_RST && column_const_mode == COL_MODE_RST
    && !scroll_active)
    else $error("soft reset left registers changed");
  a_step_ratio: assert property ( // [RULE17]
    $stable(cur_sel) ##1 $stable(cur_sel)
    |-> {4'h0, step_current_ua} * 15'd15 <= full_scale_ua
    && {4'h0, step_current_ua} * 15'd15 > full_scale_ua - 15'd15)
    else $error("current step is not one fifteenth of full scale");
endmodule : lmsc_ctrl

// File: testbench/lmsc_host.sv
// Purpose: host side model driving the register port
// Assumes: strobes change on the falling edge of core_clk
// Notes: idle address and data are inverted junk, never stale
`timescale 1ns/10ps
module lmsc_host (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // quiet bus at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // release: inverted lines so a stale value never looks valid
  task automatic idle();
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle
  // one strobe cycle per write, taken at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    idle();
  endtask : wr
  // read data is registered, so sample a full cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    idle();
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : lmsc_host

// File: testbench/tb_led_matrix_scroll_current_ctrl.sv
// Purpose: self-checking bench of the scroll/current control bank
// Assumes: short scroll unit so code 0 frames take under a hundred cycles
// Notes: inputs change on the falling edge only
`timescale 1ns/10ps
module tb_led_matrix_scroll_current_ctrl;
  import lmsc_pkg::*;
  localparam int UNIT = 4; // shortened 0.1 s step
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en, reg_rd_en, register_map_select = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic matrix_enable = 1'b1, scroll_enable = 1'b0;
  logic [1:0] display_ram_select = 2'h2;
  logic external_clock_select = 1'b0, int_osc_tick = 1'b0;
  logic ext_clk_pin = 1'b0;
  logic [4*NUM_COLS-1:0] first_row_brightness = '0;
  logic soft_reset_active, scroll_active, scroll_shift, frame_done;
  lmsc_dir_type scroll_dir;
  logic [4:0] scroll_offset;
  logic [1:0] shown_ram_select;
  logic [NUM_COLS-1:0] column_const_mode;
  logic [14:0] full_scale_ua, fs;
  logic [10:0] step_current_ua;
  logic [15*NUM_COLS-1:0] column_current_ua;
  int miscompares = 0, check_count = 0, n, g0, i;
  lmsc_dir_type dirs[4] = '{DIR_LEFT, DIR_RIGHT, DIR_DOWN, DIR_UP};
  logic [7:0] bad[3] = '{8'h50, 8'h00, 8'h78}; // conflicts and none
  always #50 core_clk = ~core_clk;
  lmsc_host lmsc_host_i (.core_clk, .reg_rdata, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata);
  lmsc_ctrl #(.SCROLL_UNIT(UNIT)) lmsc_ctrl_i (.core_clk, .rst_n,
    .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .register_map_select, .matrix_enable, .scroll_enable,
    .display_ram_select, .external_clock_select, .int_osc_tick,
    .ext_clk_pin, .first_row_brightness, .soft_reset_active,
    .scroll_active, .scroll_dir, .scroll_offset, .scroll_shift,
    .frame_done, .shown_ram_select, .column_const_mode,
    .full_scale_ua, .step_current_ua, .column_current_ua);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    lmsc_host_i.rd(a, v);
    chk(v, exp, "readback");
  endtask : rchk
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc
  // bounded wait for a shift (sel 0) or a frame wrap (sel 1)
  task automatic wait_ev(input int sel, output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (!((sel == 0) ? scroll_shift === 1'b1 : frame_done === 1'b1)
               && k < 2000);
    if (k >= 2000) chk(0, 1, "event wait");
  endtask : wait_ev
  // shifts counted up to and including the wrap
  task automatic count_frame(output int s);
    s = 0;
    for (int k = 0; k < 2000 && frame_done !== 1'b1; k++) begin
      cyc(1);
      if (scroll_shift === 1'b1) s++;
    end
  endtask : count_frame
  // one edge of whichever operating clock is chosen
  task automatic clk_edge();
    if (external_clock_select) begin
      ext_clk_pin = 1'b1;
      cyc(4);
      ext_clk_pin = 1'b0;
    end else begin
      int_osc_tick = 1'b1;
      cyc(1);
      int_osc_tick = 1'b0;
    end
    cyc(4);
  endtask : clk_edge
  task automatic start_scroll(input logic [7:0] cfg);
    lmsc_host_i.wr(ADDR_SCROLL_CONFIG, cfg);
    scroll_enable = 1'b1;
    cyc(2);
  endtask : start_scroll
  task automatic stop_scroll();
    scroll_enable = 1'b0;
    cyc(2);
  endtask : stop_scroll
  task automatic final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // watchdog: the whole sequence needs about a thousand cycles
  initial begin
    #(30000 * 100);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(12);
    rst_n = 1'b1;
    cyc(2);
    chk(full_scale_ua, 20000, "full scale");
    chk(step_current_ua, 1333, "step");
    rchk(ADDR_SCROLL_CONFIG, 8'h08);
    rchk(ADDR_SOFT_RESET, 8'h00);
    rchk(ADDR_COL_HIGH, 8'h00);
    rchk(ADDR_COL_MID, 8'h00);
    rchk(ADDR_COL_LOW, 8'h00);
    rchk(ADDR_CURRENT, 8'h01);
    rchk(8'h0c, 8'h00); // unmapped offset
    for (i = 0; i < 4; i++) begin
      lmsc_host_i.wr(ADDR_CURRENT, {6'h3f, i[1:0]});
      cyc(3);
      fs = 15'(15000 + 5000 * i);
      chk(full_scale_ua, fs, "full scale");
      chk(step_current_ua, fs / 15, "step");
      rchk(ADDR_CURRENT, 8'(i));
    end
    // column drive: edge columns, then column 1 via the mid register
    first_row_brightness[3:0] = 4'hf;
    first_row_brightness[7:4] = 4'h7;
    first_row_brightness[67:64] = 4'h3;
    lmsc_host_i.wr(ADDR_COL_HIGH, 8'h80);
    lmsc_host_i.wr(ADDR_COL_LOW, 8'h01);
    cyc(3);
    chk(column_const_mode, 17'h10001, "col mode");
    chk(column_current_ua[14:0], 30000, "col0");
    chk(column_current_ua[254:240], 6000, "col16");
    chk(column_current_ua[29:15], 0, "col1 off");
    lmsc_host_i.wr(ADDR_COL_MID, 8'h01);
    cyc(3);
    chk(column_current_ua[29:15], 14000, "col1 on");
    // map select high hides the whole bank
    register_map_select = 1'b1;
    lmsc_host_i.wr(ADDR_CURRENT, 8'h00);
    register_map_select = 1'b0;
    cyc(2);
    chk(full_scale_ua, 30000, "hidden write");
    rchk(ADDR_CURRENT, 8'h03);
    // no start without the matrix enable
    matrix_enable = 1'b0;
    start_scroll(8'h08);
    cyc(10);
    chk(scroll_active, 0, "gated start");
    stop_scroll();
    matrix_enable = 1'b1;
    for (i = 0; i < 4; i++) begin
      start_scroll(8'h08 << i);
      chk(scroll_active, 1, "start");
      chk(scroll_dir, dirs[i], "dir");
      count_frame(n);
      chk(n, (i < 2) ? 17 : 7, "frame len");
      stop_scroll();
    end
    // step time: code 7 interval is seven units longer than code 0
    start_scroll(8'h08);
    wait_ev(0, n);
    chk(scroll_offset, 1, "offset");
    wait_ev(0, g0);
    stop_scroll();
    start_scroll(8'h0f);
    wait_ev(0, n);
    wait_ev(0, n);
    chk(n - g0, 7 * UNIT, "step time");
    // new direction waits for the frame wrap
    lmsc_host_i.wr(ADDR_SCROLL_CONFIG, 8'h17);
    cyc(2);
    chk(scroll_dir, DIR_LEFT, "old dir");
    wait_ev(1, n);
    cyc(1);
    chk(scroll_dir, DIR_RIGHT, "new dir");
    // conflict while running stops at once
    display_ram_select = 2'h1;
    lmsc_host_i.wr(ADDR_SCROLL_CONFIG, 8'h18);
    cyc(2);
    chk(scroll_active, 0, "stop");
    chk(shown_ram_select, 2'h1, "ram");
    for (i = 0; i < 3; i++) begin
      stop_scroll();
      start_scroll(bad[i]);
      cyc(8);
      chk(scroll_active, 0, "bad dir");
      chk(shown_ram_select, display_ram_select, "ram");
    end
    // soft reset: held without clock edges, clears after two
    start_scroll(8'h08);
    lmsc_host_i.wr(ADDR_SOFT_RESET, 8'h01);
    cyc(2);
    chk(scroll_active, 0, "idle");
    rchk(ADDR_CURRENT, 8'h01);
    rchk(ADDR_COL_HIGH, 8'h00);
    rchk(ADDR_SOFT_RESET, 8'h01);
    for (i = 0; i < 2; i++) begin
      external_clock_select = i[0];
      if (i == 1) lmsc_host_i.wr(ADDR_SOFT_RESET, 8'h01);
      cyc(20);
      chk(soft_reset_active, 1, "no clock");
      clk_edge();
      chk(soft_reset_active, 1, "one edge");
      clk_edge();
      chk(soft_reset_active, 0, "two edges");
    end
    rchk(ADDR_SOFT_RESET, 8'h00);
    final_report();
  end
endmodule : tb_led_matrix_scroll_current_ctrl
